// file: hw/bridge_tail_pkg.sv
// constants for the bridge header tail register bank
// Contract
// - The first capability offset register reads a fixed 88h and ignores writes.
// - The interrupt routing byte is read/write, resets to 00h and steers no logic.
// - The interrupt pin register reads a fixed 01h, naming the first legacy line.
// - Bridge control bits 11..7 and 5 read zero and ignore writes; bits 15:12 are reserved.
// - Setting bit 6 requests a hot reset of the link, via Recovery, from L0, L0s or L1.
// - Bit 4 clear gives 10-bit VGA I/O decode, set gives 16-bit, only with VGA routing on.
// - Bit 3 decides whether processor VGA I/O and memory accesses go to the secondary link.
// - Bit 2 set blocks I/O window accesses in the last 768 bytes of each 1 KB block.
// - Bit 1 gates forwarding of correctable, nonfatal, fatal messages to system error.
// - Only with bit 0 set may a poisoned read completion set the master data parity flag.
package bridge_tail_pkg;
	localparam logic [7:0]  CAP_PTR_OFFSET   = 8'h34;
	localparam logic [7:0]  INT_ROUTE_OFFSET = 8'h3C;
	localparam logic [7:0]  INT_PIN_OFFSET   = 8'h3D;
	localparam logic [7:0]  BRIDGE_CTL_LO    = 8'h3E;
	localparam logic [7:0]  BRIDGE_CTL_HI    = 8'h3F;
	localparam logic [7:0]  CAP_PTR_VALUE    = 8'h88;
	localparam logic [7:0]  INT_ROUTE_RESET  = 8'h00;
	localparam logic [7:0]  INT_PIN_VALUE    = 8'h01;
	localparam logic [15:0] BRIDGE_CTL_RESET = 16'h0000;
	localparam logic [15:0] BRIDGE_CTL_WMASK = 16'h005F;
	localparam int          BIT_PARITY       = 0;
	localparam int          BIT_SERR         = 1;
	localparam int          BIT_ISA          = 2;
	localparam int          BIT_VGA          = 3;
	localparam int          BIT_VGA16        = 4;
	localparam int          BIT_HOTRST       = 6;
	localparam logic [9:0]  ISA_ALIAS_START  = 10'h100;
	localparam logic [9:0]  VGA_IO_LO_A      = 10'h3B0;
	localparam logic [9:0]  VGA_IO_HI_A      = 10'h3BB;
	localparam logic [9:0]  VGA_IO_LO_B      = 10'h3C0;
	localparam logic [9:0]  VGA_IO_HI_B      = 10'h3DF;
	localparam logic [31:0] VGA_MEM_LO       = 32'h000A0000;
	localparam logic [31:0] VGA_MEM_HI       = 32'h000BFFFF;
	localparam logic [5:0]  IO_HIGH_ZERO     = 6'h00;
	typedef enum logic [1:0] {LINK_ACTIVE, LINK_RECOVERY, LINK_HOTRESET} link_state_t;
endpackage : bridge_tail_pkg

// file: hw/byte_lane_reg.sv
// one write-masked configuration byte with reset value
`timescale 1ns/10ps
module byte_lane_reg #(
	parameter logic [7:0] RESET_VAL = 8'h00,
	parameter logic [7:0] WMASK     = 8'hFF
) (
	// clocking
	input  wire logic       ref_clk,
	input  wire logic       rst_n,
	input  wire logic       clkEn,
	// write port
	input  wire logic       wrEn,
	input  wire logic [7:0] wrData,
	// value
	output logic      [7:0] value
);
	// only masked bits take writes, the rest hold reset value
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			value <= RESET_VAL;
		end else if (clkEn && wrEn) begin
			value <= (wrData & WMASK) | (RESET_VAL & ~WMASK);
		end
	end
endmodule // byte_lane_reg

// file: hw/bridge_header_tail_controls.sv
// bridge header tail registers with VGA, ISA, error and hot reset control
`timescale 1ns/10ps
module bridge_header_tail_controls (
	// clocking
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	input  wire logic        clkEn,
	// configuration access, one byte per cycle
	input  wire logic        cfgWrite,
	input  wire logic        cfgRead,
	input  wire logic [7:0]  cfgAddr,
	input  wire logic [7:0]  cfgWrData,
	output logic      [7:0]  cfgRdData,
	output logic             cfgRdValid,
	// processor access decode
	input  wire logic        cpuIoValid,
	input  wire logic        cpuMemValid,
	input  wire logic [31:0] cpuAddr,
	input  wire logic [15:0] ioWindowBase,
	input  wire logic [15:0] ioWindowLimit,
	output logic             forwardToLink,
	// link state
	input  wire logic        linkInL0,
	input  wire logic        linkInL0s,
	input  wire logic        linkInL1,
	input  wire logic        recoveryDone,
	output logic             hotResetRequest,
	output logic             linkInRecovery,
	// errors
	input  wire logic        errCorMsg,
	input  wire logic        errNonfatalMsg,
	input  wire logic        errFatalMsg,
	input  wire logic        rootCorEnable,
	input  wire logic        rootNonfatalEnable,
	input  wire logic        rootFatalEnable,
	output logic             systemErrorMsg,
	input  wire logic        poisonedReadCompletion,
	input  wire logic        masterParityClear,
	output logic             masterDataParityError
);
	logic [7:0]  interruptRoutingValue;
	logic [7:0]  ctlLow;
	logic [7:0]  ctlHigh;
	logic [15:0] bridgeControl;
	logic        next_forward;
	logic        vgaIoHit;
	logic        vgaMemHit;
	logic        ioInWindow;
	logic        isaAliasHit;
	logic [9:0]  ioLow;
	bridge_tail_pkg::link_state_t linkState;

	assign bridgeControl = {ctlHigh, ctlLow};

	// interrupt routing byte, read/write, steers nothing
	byte_lane_reg #(
		.RESET_VAL (bridge_tail_pkg::INT_ROUTE_RESET),
		.WMASK     (8'hFF)
	) u_int_route (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.clkEn   (clkEn),
		.wrEn    (cfgWrite && cfgAddr == bridge_tail_pkg::INT_ROUTE_OFFSET),
		.wrData  (cfgWrData),
		.value   (interruptRoutingValue)
	);

	// bridge control low byte, bits 5 and 7 hardwired zero
	byte_lane_reg #(
		.RESET_VAL (bridge_tail_pkg::BRIDGE_CTL_RESET[7:0]),
		.WMASK     (bridge_tail_pkg::BRIDGE_CTL_WMASK[7:0])
	) u_ctl_lo (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.clkEn   (clkEn),
		.wrEn    (cfgWrite && cfgAddr == bridge_tail_pkg::BRIDGE_CTL_LO),
		.wrData  (cfgWrData),
		.value   (ctlLow)
	);

	// bridge control high byte, wholly read-only zero
	byte_lane_reg #(
		.RESET_VAL (bridge_tail_pkg::BRIDGE_CTL_RESET[15:8]),
		.WMASK     (bridge_tail_pkg::BRIDGE_CTL_WMASK[15:8])
	) u_ctl_hi (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.clkEn   (clkEn),
		.wrEn    (cfgWrite && cfgAddr == bridge_tail_pkg::BRIDGE_CTL_HI),
		.wrData  (cfgWrData),
		.value   (ctlHigh)
	);

	// read mux, one cycle latency; unmapped offsets read zero
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			cfgRdData  <= 8'h00;
			cfgRdValid <= 1'b0;
		end else if (clkEn) begin
			cfgRdValid <= cfgRead;
			if (cfgRead) begin
				case (cfgAddr)
					bridge_tail_pkg::CAP_PTR_OFFSET:   cfgRdData <= bridge_tail_pkg::CAP_PTR_VALUE;
					bridge_tail_pkg::INT_ROUTE_OFFSET: cfgRdData <= interruptRoutingValue;
					bridge_tail_pkg::INT_PIN_OFFSET:   cfgRdData <= bridge_tail_pkg::INT_PIN_VALUE;
					bridge_tail_pkg::BRIDGE_CTL_LO:    cfgRdData <= ctlLow;
					bridge_tail_pkg::BRIDGE_CTL_HI:    cfgRdData <= ctlHigh;
					default:                           cfgRdData <= 8'h00;
				endcase
			end
		end
	end

	// hot reset sequencing: active link goes via recovery into hot reset
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			linkState <= bridge_tail_pkg::LINK_ACTIVE;
		end else if (clkEn) begin
			case (linkState)
				bridge_tail_pkg::LINK_ACTIVE: begin
					if (bridgeControl[bridge_tail_pkg::BIT_HOTRST] &&
						(linkInL0 || linkInL0s || linkInL1)) begin
						linkState <= bridge_tail_pkg::LINK_RECOVERY;
					end
				end
				bridge_tail_pkg::LINK_RECOVERY: begin
					if (recoveryDone) begin
						linkState <= bridge_tail_pkg::LINK_HOTRESET;
					end
				end
				bridge_tail_pkg::LINK_HOTRESET: begin
					if (!bridgeControl[bridge_tail_pkg::BIT_HOTRST]) begin
						linkState <= bridge_tail_pkg::LINK_ACTIVE;
					end
				end
				default: linkState <= bridge_tail_pkg::LINK_ACTIVE;
			endcase
		end
	end

	// link state outputs registered
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			hotResetRequest <= 1'b0;
			linkInRecovery  <= 1'b0;
		end else if (clkEn) begin
			hotResetRequest <= (linkState == bridge_tail_pkg::LINK_HOTRESET);
			linkInRecovery  <= (linkState == bridge_tail_pkg::LINK_RECOVERY);
		end
	end

	// processor access routing decode
	always_comb begin
		ioLow     = cpuAddr[9:0];
		// display port I/O only below 64 KB, like every other I/O access
		vgaIoHit  = cpuAddr[31:16] == 16'h0000 &&
			((ioLow >= bridge_tail_pkg::VGA_IO_LO_A && ioLow <= bridge_tail_pkg::VGA_IO_HI_A) ||
			(ioLow >= bridge_tail_pkg::VGA_IO_LO_B && ioLow <= bridge_tail_pkg::VGA_IO_HI_B)) &&
			(!bridgeControl[bridge_tail_pkg::BIT_VGA16] ||
			cpuAddr[15:10] == bridge_tail_pkg::IO_HIGH_ZERO);
		vgaMemHit = cpuAddr >= bridge_tail_pkg::VGA_MEM_LO && cpuAddr <= bridge_tail_pkg::VGA_MEM_HI;
		ioInWindow = cpuAddr[15:0] >= ioWindowBase && cpuAddr[15:0] <= ioWindowLimit &&
			cpuAddr[31:16] == 16'h0000;
		isaAliasHit = ioLow >= bridge_tail_pkg::ISA_ALIAS_START;
		next_forward = 1'b0;
		if (cpuIoValid) begin
			if (bridgeControl[bridge_tail_pkg::BIT_VGA] && vgaIoHit) begin
				next_forward = 1'b1;
			end else if (ioInWindow &&
				!(bridgeControl[bridge_tail_pkg::BIT_ISA] && isaAliasHit)) begin
				next_forward = 1'b1;
			end
		end else if (cpuMemValid) begin
			next_forward = bridgeControl[bridge_tail_pkg::BIT_VGA] && vgaMemHit;
		end
	end

	// registered routing answer
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			forwardToLink <= 1'b0;
		end else if (clkEn) begin
			forwardToLink <= next_forward;
		end
	end

	// error message forwarding to system error
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			systemErrorMsg <= 1'b0;
		end else if (clkEn) begin
			systemErrorMsg <= bridgeControl[bridge_tail_pkg::BIT_SERR] &&
				((errCorMsg && rootCorEnable) || (errNonfatalMsg && rootNonfatalEnable) ||
				(errFatalMsg && rootFatalEnable));
		end
	end

	// master data parity flag; set wins over clear
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			masterDataParityError <= 1'b0;
		end else if (clkEn) begin
			if (poisonedReadCompletion && bridgeControl[bridge_tail_pkg::BIT_PARITY]) begin
				masterDataParityError <= 1'b1;
			end else if (masterParityClear) begin
				masterDataParityError <= 1'b0;
			end
		end
	end
endmodule // bridge_header_tail_controls

// file: sim/bridge_tail_checker.sv
// concurrent checks on the bridge header tail register bank
`timescale 1ns/10ps
module bridge_tail_checker (
	input wire logic        ref_clk, rst_n, clkEn, cfgWrite, cfgRead, cfgRdValid,
	input wire logic        cpuIoValid, cpuMemValid, forwardToLink, hotResetRequest,
	input wire logic        linkInL0, linkInL0s, linkInL1, errCorMsg, rootCorEnable,
	input wire logic        systemErrorMsg, poisonedReadCompletion, masterDataParityError,
	input wire logic [7:0]  cfgAddr, cfgWrData, cfgRdData,
	input wire logic [31:0] cpuAddr,
	input wire logic [15:0] ioWindowBase, ioWindowLimit
);
	logic [7:0] ctl;
	logic       vgaIo;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	// shadow of the writable bridge control bits
	always_ff @(posedge ref_clk) begin
		if (!rst_n) ctl <= 8'h00;
		else if (clkEn && cfgWrite && cfgAddr == 8'h3E) ctl <= cfgWrData & 8'h5F;
	end
	// display port hit under the chosen decode width
	assign vgaIo = ctl[3] && cpuAddr[31:16] == 16'h0 && (!ctl[4] || cpuAddr[15:10] == 6'h0)
		&& (cpuAddr[9:0] inside {[10'h3B0:10'h3BB], [10'h3C0:10'h3DF]});
	property p_cap; cfgRead && cfgAddr == 8'h34 |=> cfgRdValid && cfgRdData == 8'h88; endproperty
	a_cap: assert property (p_cap) else $error("capability offset wrong");
	property p_pin; cfgRead && cfgAddr == 8'h3D |=> cfgRdData == 8'h01; endproperty
	a_pin: assert property (p_pin) else $error("pin code wrong");
	property p_ctl; cfgRead && !cfgWrite && cfgAddr == 8'h3E |=> cfgRdData == $past(ctl); endproperty
	a_ctl: assert property (p_ctl) else $error("control byte wrong");
	property p_hot; ctl[6] && (linkInL0 || linkInL0s || linkInL1) |-> ##[1:16] hotResetRequest;
	endproperty
	a_hot: assert property (p_hot) else $error("hot reset missing");
	property p_vga; cpuIoValid && !cpuMemValid && ioWindowBase > ioWindowLimit
		|=> forwardToLink == $past(vgaIo); endproperty
	a_vga: assert property (p_vga) else $error("display port decode wrong");
	property p_isa; cpuIoValid && !cpuMemValid && ctl[2] && !ctl[3] && cpuAddr[9:8] != 2'h0
		|=> !forwardToLink; endproperty
	a_isa: assert property (p_isa) else $error("alias not blocked");
	property p_serr; ctl[1] && errCorMsg && rootCorEnable |=> systemErrorMsg; endproperty
	a_serr: assert property (p_serr) else $error("system error missing");
	property p_par; $rose(masterDataParityError) |-> $past(ctl[0] && poisonedReadCompletion);
	endproperty
	a_par: assert property (p_par) else $error("parity flag set wrongly");
	c_hot: cover property (hotResetRequest);
	c_fwd: cover property (cpuIoValid ##1 forwardToLink);
	c_par: cover property (masterDataParityError);
endmodule // bridge_tail_checker
bind bridge_header_tail_controls bridge_tail_checker u_bridge_tail_checker (.*);

// file: sim/link_partner_model.sv
// downstream link partner: power state and recovery completion
`timescale 1ns/10ps
module link_partner_model (
	input wire logic       ref_clk, rst_n, slow, linkInRecovery, hotResetRequest,
	input wire logic [1:0] pmState,
	output logic           linkInL0, linkInL0s, linkInL1, recoveryDone
);
	logic [3:0] dly;
	// link state vanishes while the hot reset is held
	assign {linkInL0, linkInL0s, linkInL1} = hotResetRequest ? 3'h0 : 3'h4 >> pmState;
	// recovery finishes after a short or long pause
	always_ff @(posedge ref_clk) dly <= (!rst_n || !linkInRecovery) ? 4'h0 : dly + 4'(dly != 4'hF);
	assign recoveryDone = linkInRecovery && dly >= (slow ? 4'h8 : 4'h1);
endmodule // link_partner_model

// file: sim/tb_bridge_header_tail_controls.sv
// randomised self-checking bench for the bridge header tail registers
`timescale 1ns/10ps
module tb_bridge_header_tail_controls;
	logic ref_clk = 0, rst_n = 0, cfgWrite = 0, cfgRead = 0, cpuIoValid = 0, cpuMemValid = 0;
	logic errCorMsg = 0, errNonfatalMsg = 0, errFatalMsg = 0, poisonedReadCompletion = 0;
	logic masterParityClear = 0, rootCorEnable = 0, rootNonfatalEnable = 0, rootFatalEnable = 0;
	logic slow = 0, cfgRdValid, forwardToLink, hotResetRequest, linkInRecovery, systemErrorMsg;
	logic masterDataParityError, linkInL0, linkInL0s, linkInL1, recoveryDone;
	logic [1:0]  pmState = 0;
	logic [7:0]  cfgAddr = 0, cfgWrData = 0, cfgRdData, ctl = 0, rnd;
	logic [15:0] ioWindowBase = 0, ioWindowLimit = 0;
	logic [31:0] cpuAddr = 0, a;
	logic [31:0] corner [8] = '{32'h3B0, 32'h3BB, 32'h3BC, 32'h3DF, 32'h7C0, 32'h100, 32'hA0000,
		32'hC0000};
	int miscompares = 0, nTests = 0, cyc = 0;
	always #2 ref_clk = ~ref_clk;
	bridge_header_tail_controls u_bridge_header_tail_controls (.clkEn(1'b1), .*);
	link_partner_model u_link_partner_model (.*);
	// expected forwarding of one processor access
	function logic fwd(logic io, logic [31:0] x);
		return ctl[3] && (io ? x[31:16] == 0 && (!ctl[4] || x[15:10] == 0)
			&& x[9:0] inside {[10'h3B0:10'h3BB], [10'h3C0:10'h3DF]} : x inside {[32'hA0000:32'hBFFFF]})
			|| io && x[31:16] == 0 && x[15:0] >= ioWindowBase && x[15:0] <= ioWindowLimit
			&& !(ctl[2] && x[9:8] != 0);
	endfunction
	task chk(logic [7:0] s, e);
		nTests++;
		if (s !== e) begin
			miscompares++;
			$display("wrong value at %0t: saw %h expected %h", $time, s, e);
		end
	endtask
	task stopTest;
		$display("mismatches %0d of %0d checks", miscompares, nTests);
		if (miscompares == 0 && nTests > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task wr(logic [7:0] ad, d);
		@(negedge ref_clk) {cfgWrite, cfgAddr, cfgWrData} = {1'b1, ad, d};
		@(negedge ref_clk) cfgWrite = 0;
		if (ad == 8'h3E) ctl = d & 8'h5F;
	endtask
	task rd(logic [7:0] ad, e);
		@(negedge ref_clk) {cfgRead, cfgAddr} = {1'b1, ad};
		@(negedge ref_clk) cfgRead = 0;
		chk(cfgRdValid, 1);
		chk(cfgRdData, e);
	endtask
	// hang guard
	always @(posedge ref_clk) if (++cyc == 20000) begin
		miscompares++;
		stopTest;
	end
	initial begin
		void'($urandom(66948));
		repeat (4) @(negedge ref_clk);
		rst_n = 1;
		rd(8'h34, 8'h88);
		rd(8'h3D, 8'h01);
		rd(8'h3E, 8'h00);
		rd(8'h3F, 8'h00);
		// fixed places ignore writes, control keeps only writable bits
		for (int i = 0; i < 4; i++) wr(8'h3C + i[7:0], 8'hFF);
		wr(8'h34, 8'hFF);
		rd(8'h34, 8'h88);
		rd(8'h3D, 8'h01);
		rd(8'h3F, 8'h00);
		rd(8'h3E, 8'h5F);
		rnd = 8'($urandom);
		wr(8'h3C, rnd);
		rd(8'h3C, rnd);
		@(negedge ref_clk) rst_n = 0;
		@(negedge ref_clk) rst_n = 1;
		ctl = 0;
		rd(8'h3E, 8'h00);
		rd(8'h3C, 8'h00);
		// hot reset from each link power state, short and long recovery
		for (int p = 0; p < 3; p++) begin
			{pmState, slow} = {p[1:0], p[0]};
			wr(8'h3E, 8'h40);
			for (int k = 0; k < 40 && !hotResetRequest; k++) @(negedge ref_clk);
			chk(hotResetRequest, 1);
			wr(8'h3E, 8'h00);
			repeat (2) @(negedge ref_clk);
			chk(hotResetRequest, 0);
		end
		// random decode traffic with boundary addresses mixed in
		for (int i = 0; i < 300; i++) begin
			wr(8'h3E, 8'($urandom) & 8'h1C);
			ioWindowBase = ctl[3] ? 16'hFFFF : 16'($urandom) & 16'h0FFF;
			ioWindowLimit = ctl[3] ? 16'h0 : ioWindowBase + (16'($urandom) & 16'h0FFF);
			a = i % 3 == 0 ? corner[(i / 3) % 8] : $urandom & (i[0] ? 32'hFFFFF : 32'hFFFF);
			@(negedge ref_clk) {cpuIoValid, cpuMemValid, cpuAddr} = {i[1], !i[1], a};
			@(negedge ref_clk) {cpuIoValid, cpuMemValid} = 2'h0;
			chk(forwardToLink, fwd(i[1], a));
		end
		// error messages gated by the forward bit and root enables
		for (int i = 0; i < 40; i++) begin
			rnd = 8'($urandom);
			wr(8'h3E, {6'h0, rnd[6], 1'b0});
			{rootCorEnable, rootNonfatalEnable, rootFatalEnable} = rnd[2:0];
			@(negedge ref_clk) {errCorMsg, errNonfatalMsg, errFatalMsg} = rnd[5:3];
			@(negedge ref_clk) {errCorMsg, errNonfatalMsg, errFatalMsg} = 3'h0;
			chk(systemErrorMsg, ctl[1] && |(rnd[2:0] & rnd[5:3]));
		end
		// poisoned completion with parity response off, then on
		for (int i = 0; i < 2; i++) begin
			wr(8'h3E, i[7:0]);
			@(negedge ref_clk) poisonedReadCompletion = 1;
			@(negedge ref_clk) poisonedReadCompletion = 0;
			chk(masterDataParityError, i[0]);
			@(negedge ref_clk) masterParityClear = 1;
			@(negedge ref_clk) masterParityClear = 0;
			chk(masterDataParityError, 0);
		end
		stopTest;
	end
endmodule // tb_bridge_header_tail_controls
